// ==== core/ssp_pkg.sv ====
package ssp_pkg;

	// Register byte offsets on the Avalon-MM slave
	localparam logic [5:0] SSP_OFF_CTRL0   = 6'h00;
	localparam logic [5:0] SSP_OFF_CTRL1   = 6'h04;
	localparam logic [5:0] SSP_OFF_DATA    = 6'h08;
	localparam logic [5:0] SSP_OFF_STATUS  = 6'h0C;
	localparam logic [5:0] SSP_OFF_PRESC   = 6'h10;
	localparam logic [5:0] SSP_OFF_IMASK   = 6'h14;
	localparam logic [5:0] SSP_OFF_RIS     = 6'h18;
	localparam logic [5:0] SSP_OFF_MIS     = 6'h1C;
	localparam logic [5:0] SSP_OFF_ICR     = 6'h20;

	// Field positions in control_zero_register
	localparam int SSP_C0_DSS_LSB = 0;
	localparam int SSP_C0_FRF_LSB = 4;
	localparam int SSP_C0_POL_BIT = 6;
	localparam int SSP_C0_PHA_BIT = 7;
	localparam int SSP_C0_SCR_LSB = 8;
	// Field positions in the control one register
	localparam int SSP_C1_EN_BIT  = 1;
	localparam int SSP_C1_SLV_BIT = 2;
	localparam int SSP_C1_DMA_BIT = 3;
	// Interrupt bit positions (overrun, time-out, rx service, tx service)
	localparam int SSP_IRQ_ROR = 0;
	localparam int SSP_IRQ_RTO = 1;
	localparam int SSP_IRQ_RX  = 2;
	localparam int SSP_IRQ_TX  = 3;

	// Values after reset
	localparam logic [15:0] SSP_CTRL0_RST = 16'h0007;
	localparam logic [3:0]  SSP_CTRL1_RST = 4'h0;
	localparam logic [7:0]  SSP_PRESC_RST = 8'h02;
	localparam logic [7:0]  SSP_PRESC_MIN = 8'h02;
	localparam logic [3:0]  SSP_IMASK_RST = 4'h0;

	// Buffer geometry and thresholds
	localparam int          SSP_DW        = 16;
	localparam int          SSP_DEPTH     = 8;
	localparam logic [3:0]  SSP_TX_LEVEL  = 4'h4;
	localparam logic [3:0]  SSP_RX_LEVEL  = 4'h4;
	localparam logic [3:0]  SSP_FULL      = 4'h8;
	localparam logic [5:0]  SSP_CMD_BITS  = 6'h08;
	// Receive time-out in idle serial bit periods
	localparam logic [5:0]  SSP_RTO_BITS  = 6'h20;

	// Frame formats
	typedef enum logic [1:0] {
		SSP_FMT_SPI = 2'h0,
		SSP_FMT_TI  = 2'h1,
		SSP_FMT_MW  = 2'h2
	} ssp_fmt_e;

	// Engine states
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_LEAD = 4'b0010,
		ST_BITS = 4'b0100,
		ST_TAIL = 4'b1000
	} ssp_state_e;

endpackage : ssp_pkg

// ==== core/ssp_core.sv ====
// Functional notes
// - Prescaler divides the system clock by an even value from 2 to 254.
// - Second divider is one plus rate factor, 1 to 256; product sets bit rate.
// - Software keeps system clock two times (master) or twelve times (slave) the bit rate.
// - Transmit buffer is 8 words of 16 bits, filled by data register writes.
// - Receive buffer is 8 words of 16 bits; each word is registered before loading.
// - Slave started on empty transmit buffer resends the eighth most recent word.
// - With fewer than eight words ever written, such a slave frame sends zero.
// - Transmit buffer empty can raise an interrupt or a DMA request.
// - Four interrupt sources, masked, ORed into one request.
// - Each source has a mask bit; a one enables it.
// - Raw and masked interrupt state are both readable.
// - Frames carry 4 to 16 bits, most significant bit first; the code accepts any data size from 1 to 16 bits.
// - Receive time-out flags when the link stays idle while receive data waits.
// - Select and command formats use an active low select held for the whole frame.
// - Pulsed-frame format drives data on rising and samples on falling edges.
// - Pulsed-frame idle: clock and select low, data output tristated.
// - Pulsed-frame start: select high one clock period, then MSB on next rise.
// - Pulsed-frame received word loads on the first rise after the LSB; as slave the code loads it at the LSB capture edge.
// - Command format: 8-bit command out, one clock wait, 4 to 16 bits back; the code takes 1 to 16 bits back.
// - Select format: idle clock level follows the polarity bit.
// - Select format: phase bit clear samples on first edge, set on second.
// - Select format, phase clear: select goes high between back-to-back words.
// - Select format, phase set: select stays low between continuous words.
// - Select format: select returns high one period after the last capture.
//
// The Avalon-MM register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module ssp_core (
	input  wire logic        clk_i,
	input  wire logic        reset_n_i,
	input  wire logic [5:0]  avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	output logic      [31:0] avs_readdata_o,
	output logic             avs_waitrequest_o,
	input  wire logic        serial_clock_pin_i,
	output logic             serial_clock_pin_o,
	output logic             serial_clock_pin_oe_o,
	input  wire logic        frame_select_pin_i,
	output logic             frame_select_pin_o,
	output logic             frame_select_pin_oe_o,
	output logic             serial_out_pin_o,
	output logic             serial_out_pin_oe_o,
	input  wire logic        serial_in_pin_i,
	output logic             irq_o,
	output logic             dma_tx_req_o
);
	import ssp_pkg::*;

	// Maps a frame bit index onto its direction role for the current format
	function automatic logic bit_used(input logic [5:0] b, input logic [1:0] f, input logic slv,
					  input logic tx, input logic [5:0] n);
		logic cmd_part;
		cmd_part = (b < SSP_CMD_BITS);
		case (f)
			SSP_FMT_TI: bit_used = (b != 6'h00);
			SSP_FMT_MW: bit_used = (tx ^ slv) ? cmd_part : (b > SSP_CMD_BITS);
			default:    bit_used = (b < n);
		endcase
	endfunction : bit_used

	// Left-aligns a transmit word so the shifter always leaves from bit 15
	function automatic logic [15:0] align_word(input logic [15:0] w, input logic [1:0] f,
						   input logic slv, input logic [3:0] dss);
		logic [4:0] sh;
		sh = (f == SSP_FMT_MW && !slv) ? 5'd8 : 5'd15 - {1'b0, dss};
		align_word = w << sh;
	endfunction : align_word

	// Register state
	logic [15:0] ctrl0_r;
	logic [3:0]  ctrl1_r;
	logic [7:0]  presc_r;
	logic [3:0]  imask_r;
	logic        ror_r, rto_r;
	logic [31:0] rdata_r;
	logic        wait_r;

	// Configuration decode
	wire logic [3:0] dss    = ctrl0_r[SSP_C0_DSS_LSB +: 4];
	wire logic [1:0] fmt    = ctrl0_r[SSP_C0_FRF_LSB +: 2];
	wire logic       pol    = ctrl0_r[SSP_C0_POL_BIT];
	wire logic       pha    = ctrl0_r[SSP_C0_PHA_BIT];
	wire logic [7:0] serial_rate_factor    = ctrl0_r[SSP_C0_SCR_LSB +: 8];
	wire logic       enable = ctrl1_r[SSP_C1_EN_BIT];
	wire logic       slave  = ctrl1_r[SSP_C1_SLV_BIT];
	wire logic       is_spi = (fmt == SSP_FMT_SPI);
	wire logic       is_ti  = (fmt == SSP_FMT_TI);
	wire logic [5:0] nbits  = {2'b00, dss} + 6'h01;
	wire logic [5:0] total  = is_ti ? nbits + 6'h01 : (fmt == SSP_FMT_MW) ? nbits + 6'h09 : nbits;
	// Pulsed-frame and phase-set select-format frames launch data on the first edge
	wire logic       launch_first = is_ti | (is_spi & pha);

	// Bus access decode: taken while waitrequest is still high, answered next edge
	wire logic       acc    = (avs_read_i | avs_write_i) & wait_r;
	wire logic       wr_acc = acc & avs_write_i;
	wire logic       rd_acc = acc & avs_read_i;
	wire logic       sel_data = (avs_address_i == SSP_OFF_DATA);

	// Buffers
	logic [15:0] txm [SSP_DEPTH];
	logic [15:0] rxm [SSP_DEPTH];
	logic [2:0]  tx_wp_r, tx_rp_r, rx_wp_r, rx_rp_r;
	logic [3:0]  tx_cnt_r, rx_cnt_r;
	logic        tx_wrapped_r;
	wire logic   tx_empty = (tx_cnt_r == 4'h0);
	wire logic   rx_empty = (rx_cnt_r == 4'h0);
	wire logic   tx_full  = (tx_cnt_r == SSP_FULL);
	wire logic   rx_full  = (rx_cnt_r == SSP_FULL);

	// Pin synchronisers
	logic [1:0]  sck_s, fss_s, din_s;
	logic        sck_d, fss_d;
	wire logic   sck_edge = sck_s[1] ^ sck_d;
	wire logic   fss_fall = fss_d & ~fss_s[1];
	wire logic   fss_rise = ~fss_d & fss_s[1];

	// Bit-rate divider
	logic [6:0]  pre_cnt_r;
	logic [7:0]  rate_cnt_r;
	logic        half_tick_r, bit_tick_r, half_par_r;
	wire logic [6:0] pre_last = presc_r[7:1] - 7'h01;

	// Engine
	ssp_state_e  st_r;
	logic [5:0]  hc_r;
	logic        tail_r;
	logic [15:0] tx_sh_r, rx_sh_r;
	logic        push_r;
	logic [15:0] push_word_r;
	logic [5:0]  idle_bits_r;

	wire logic   step      = slave ? sck_edge : half_tick_r;
	wire logic [5:0] bidx  = {1'b0, hc_r[5:1]};
	wire logic   is_cap    = launch_first ? hc_r[0] : ~hc_r[0];
	wire logic [5:0] nb    = launch_first ? bidx : bidx + 6'h01;
	wire logic   last_edge = (hc_r == {total[4:0], 1'b0} - 6'h01);
	wire logic   tx_bit_on = bit_used(nb, fmt, slave, 1'b1, nbits);
	wire logic   rx_bit_on = bit_used(bidx, fmt, slave, 1'b0, nbits);
	wire logic   m_start   = enable & ~slave & ~tx_empty & half_tick_r;
	wire logic   s_start   = enable & slave & (is_ti ? fss_rise : fss_fall);
	wire logic   s_abort   = slave & ~is_ti & fss_s[1];
	wire logic   s_cont    = slave & is_spi & pha & ~fss_s[1];
	// master keeps going: phase-set select and pulsed format
	wire logic   m_cont    = ~slave & enable & ~tx_empty & (is_ti | (is_spi & pha));
	wire logic   replay_ok = tx_wrapped_r;
	wire logic [15:0] tx_src = !tx_empty ? txm[tx_rp_r] : (replay_ok ? txm[tx_wp_r] : 16'h0000);
	wire logic   load      = (st_r == ST_IDLE & (s_start | (m_start & ~slave)))
				| (st_r == ST_TAIL & half_tick_r & ~tail_r & m_cont)
				| (st_r == ST_BITS & step & last_edge & s_cont);
	wire logic [15:0] load_w = align_word(tx_src, fmt, slave, dss);
	wire logic   tx_pop    = load & ~tx_empty;
	wire logic   tx_push   = wr_acc & sel_data & ~tx_full;
	wire logic   rx_pop    = rd_acc & sel_data & ~rx_empty;

	// Interrupt state
	wire logic [3:0] ris = {tx_cnt_r <= SSP_TX_LEVEL, rx_cnt_r >= SSP_RX_LEVEL, rto_r, ror_r};
	wire logic [3:0] mis = ris & imask_r;

	// Read multiplexer
	wire logic [31:0] rd_mux =
		(avs_address_i == SSP_OFF_CTRL0)  ? {16'h0000, ctrl0_r} :
		(avs_address_i == SSP_OFF_CTRL1)  ? {28'h000_0000, ctrl1_r} :
		sel_data                          ? {16'h0000, rx_empty ? 16'h0000 : rxm[rx_rp_r]} :
		(avs_address_i == SSP_OFF_STATUS) ? {27'h000_0000, st_r != ST_IDLE, rx_full, ~rx_empty,
							~tx_full, tx_empty} :
		(avs_address_i == SSP_OFF_PRESC)  ? {24'h00_0000, presc_r} :
		(avs_address_i == SSP_OFF_IMASK)  ? {28'h000_0000, imask_r} :
		(avs_address_i == SSP_OFF_RIS)    ? {28'h000_0000, ris} :
		(avs_address_i == SSP_OFF_MIS)    ? {28'h000_0000, mis} : 32'h0000_0000;

	// Bus handshake: one wait cycle, then a single-cycle low on waitrequest
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wait_r  <= 1'b1;
			rdata_r <= 32'h0000_0000;
		end else begin
			wait_r <= ~acc;
			if (rd_acc)
				rdata_r <= rd_mux;
		end
	end

	// Software registers; writes to unmapped offsets are dropped
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ctrl0_r <= SSP_CTRL0_RST;
			ctrl1_r <= SSP_CTRL1_RST;
			presc_r <= SSP_PRESC_RST;
			imask_r <= SSP_IMASK_RST;
		end else if (wr_acc) begin
			if (avs_address_i == SSP_OFF_CTRL0)
				ctrl0_r <= avs_writedata_i[15:0];
			if (avs_address_i == SSP_OFF_CTRL1)
				ctrl1_r <= avs_writedata_i[3:0];
			if (avs_address_i == SSP_OFF_PRESC)
				presc_r <= (avs_writedata_i[7:1] == 7'h00) ? SSP_PRESC_MIN : {avs_writedata_i[7:1], 1'b0};
			if (avs_address_i == SSP_OFF_IMASK)
				imask_r <= avs_writedata_i[3:0];
		end
	end

	// two-stage divider; each half tick is half a serial clock period
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pre_cnt_r   <= 7'h00;
			rate_cnt_r  <= 8'h00;
			half_tick_r <= 1'b0;
			half_par_r  <= 1'b0;
			bit_tick_r  <= 1'b0;
		end else begin
			half_tick_r <= 1'b0;
			bit_tick_r  <= 1'b0;
			if (pre_cnt_r >= pre_last) begin
				pre_cnt_r <= 7'h00;
				if (rate_cnt_r >= serial_rate_factor) begin
					rate_cnt_r  <= 8'h00;
					half_tick_r <= 1'b1;
					half_par_r  <= ~half_par_r;
					bit_tick_r  <= half_par_r;
				end else begin
					rate_cnt_r <= rate_cnt_r + 8'h01;
				end
			end else begin
				pre_cnt_r <= pre_cnt_r + 7'h01;
			end
		end
	end

	// pin synchronisers; only the second stage and its delayed copy feed logic
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sck_s <= 2'b00;
			fss_s <= 2'b11;
			din_s <= 2'b00;
			sck_d <= 1'b0;
			fss_d <= 1'b1;
		end else begin
			sck_s <= {sck_s[0], serial_clock_pin_i};
			fss_s <= {fss_s[0], frame_select_pin_i};
			din_s <= {din_s[0], serial_in_pin_i};
			sck_d <= sck_s[1];
			fss_d <= fss_s[1];
		end
	end

	// transmit buffer; memory keeps old words for slave replay
	always_ff @(posedge clk_i) begin
		if (tx_push)
			txm[tx_wp_r] <= avs_writedata_i[15:0];
	end

	// replay is only allowed once eight words have been written
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			tx_wp_r      <= 3'h0;
			tx_rp_r      <= 3'h0;
			tx_cnt_r     <= 4'h0;
			tx_wrapped_r <= 1'b0;
		end else begin
			if (tx_push) begin
				tx_wp_r <= tx_wp_r + 3'h1;
				if (tx_wp_r == 3'h7)
					tx_wrapped_r <= 1'b1;
			end
			if (tx_pop)
				tx_rp_r <= tx_rp_r + 3'h1;
			tx_cnt_r <= tx_cnt_r + {3'h0, tx_push} - {3'h0, tx_pop};
		end
	end

	// receive buffer, loaded from the registered word
	always_ff @(posedge clk_i) begin
		if (push_r && !rx_full)
			rxm[rx_wp_r] <= push_word_r;
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rx_wp_r  <= 3'h0;
			rx_rp_r  <= 3'h0;
			rx_cnt_r <= 4'h0;
		end else begin
			if (push_r && !rx_full)
				rx_wp_r <= rx_wp_r + 3'h1;
			if (rx_pop)
				rx_rp_r <= rx_rp_r + 3'h1;
			rx_cnt_r <= rx_cnt_r + {3'h0, push_r & ~rx_full} - {3'h0, rx_pop};
		end
	end

	// Sticky status: a hardware set wins over a clear in the same cycle
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ror_r       <= 1'b0;
			rto_r       <= 1'b0;
			idle_bits_r <= 6'h00;
		end else begin
			// overrun when a word arrives at a full buffer
			if (push_r && rx_full)
				ror_r <= 1'b1;
			else if (wr_acc && avs_address_i == SSP_OFF_ICR && avs_writedata_i[SSP_IRQ_ROR])
				ror_r <= 1'b0;
			// count idle bit periods while data waits
			if (st_r != ST_IDLE || rx_empty || rx_pop)
				idle_bits_r <= 6'h00;
			else if (bit_tick_r && idle_bits_r != SSP_RTO_BITS)
				idle_bits_r <= idle_bits_r + 6'h01;
			if (bit_tick_r && idle_bits_r == SSP_RTO_BITS - 6'h01 && st_r == ST_IDLE && !rx_empty)
				rto_r <= 1'b1;
			else if (wr_acc && avs_address_i == SSP_OFF_ICR && avs_writedata_i[SSP_IRQ_RTO])
				rto_r <= 1'b0;
		end
	end

	// Serial engine: one step per half period (master) or per clock edge (slave)
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st_r                  <= ST_IDLE;
			hc_r                  <= 6'h00;
			tail_r                <= 1'b0;
			tx_sh_r               <= 16'h0000;
			rx_sh_r               <= 16'h0000;
			push_r                <= 1'b0;
			push_word_r           <= 16'h0000;
			serial_clock_pin_o    <= 1'b0;
			frame_select_pin_o    <= 1'b1;
			serial_out_pin_o      <= 1'b0;
		end else begin
			push_r <= 1'b0;
			if (load) begin
				hc_r    <= 6'h00;
				tail_r  <= 1'b0;
				rx_sh_r <= 16'h0000;
				// keep the word that ends here
				if (st_r == ST_BITS)
					push_word_r <= {rx_sh_r[14:0], din_s[1]};
				push_r  <= (st_r != ST_IDLE);
				// MSB leaves first when data goes out before the first edge
				if (!launch_first && bit_used(6'h00, fmt, slave, 1'b1, nbits)) begin
					serial_out_pin_o <= load_w[15];
					tx_sh_r          <= load_w << 1;
				end else begin
					serial_out_pin_o <= 1'b0;
					tx_sh_r          <= load_w;
				end
				// sync pulse high; select low for the frame
				frame_select_pin_o <= is_ti;
				st_r <= (slave || is_ti) ? ST_BITS : ST_LEAD;
			end else begin
				case (st_r)
				ST_IDLE: begin
					serial_clock_pin_o <= is_spi & pol;
					frame_select_pin_o <= ~is_ti;
					serial_out_pin_o   <= 1'b0;
				end
				ST_LEAD: begin
					if (half_tick_r)
						st_r <= ST_BITS;
				end
				ST_BITS: begin
					if (s_abort) begin
						st_r <= ST_IDLE;
					end else if (step) begin
						hc_r <= hc_r + 6'h01;
						// clock toggles only inside a frame
						if (!slave)
							serial_clock_pin_o <= ~serial_clock_pin_o;
						if (is_cap && rx_bit_on)
							rx_sh_r <= {rx_sh_r[14:0], din_s[1]};
						// MSB presented on the launch edge after the sync period
						if (!is_cap) begin
							serial_out_pin_o <= tx_bit_on ? tx_sh_r[15] : 1'b0;
							if (tx_bit_on)
								tx_sh_r <= tx_sh_r << 1;
							if (is_ti && hc_r == 6'h02)
								frame_select_pin_o <= 1'b0;
						end
						if (last_edge) begin
							// final word holds the bits sampled after the command as master, the command bits as slave
							push_word_r <= (is_cap && rx_bit_on) ? {rx_sh_r[14:0], din_s[1]} : rx_sh_r;
							if (slave) begin
								push_r <= 1'b1;
								st_r   <= ST_IDLE;
							end else begin
								st_r <= ST_TAIL;
							end
						end
					end
				end
				ST_TAIL: begin
					if (half_tick_r) begin
						// load on the next rising time after the last sample
						if (!tail_r)
							push_r <= 1'b1;
						tail_r <= 1'b1;
						// select high a period after the last capture
						if (tail_r || !launch_first) begin
							st_r <= ST_IDLE;
							frame_select_pin_o <= ~is_ti;
							serial_out_pin_o   <= 1'b0;
						end
					end
				end
				default: st_r <= ST_IDLE;
				endcase
			end
		end
	end

	// Pad enables and request outputs, all registered
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			serial_clock_pin_oe_o <= 1'b0;
			frame_select_pin_oe_o <= 1'b0;
			serial_out_pin_oe_o   <= 1'b0;
			irq_o                 <= 1'b0;
			dma_tx_req_o          <= 1'b0;
		end else begin
			serial_clock_pin_oe_o <= enable & ~slave;
			frame_select_pin_oe_o <= enable & ~slave;
			// data line released when the pulsed format is idle
			serial_out_pin_oe_o   <= enable & (slave ? (st_r != ST_IDLE) : (~is_ti | st_r != ST_IDLE));
			// masked sources ORed onto one request
			irq_o                 <= |mis;
			// request more data when the transmit buffer runs dry
			dma_tx_req_o          <= enable & ctrl1_r[SSP_C1_DMA_BIT] & tx_empty;
		end
	end

	assign avs_readdata_o    = rdata_r;
	assign avs_waitrequest_o = wait_r;

endmodule : ssp_core

// ==== verification/ssp_core_properties.sv ====
`timescale 1ns/1ps
// Watches the register bus and the master pins of the serial port core
module ssp_core_properties import ssp_pkg::*; (
	input wire logic        clk_i,
	input wire logic        reset_n_i,
	input wire logic [5:0]  avs_address_i,
	input wire logic        avs_read_i,
	input wire logic        avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic        avs_waitrequest_o,
	input wire logic        serial_clock_pin_o,
	input wire logic        serial_clock_pin_oe_o,
	input wire logic        frame_select_pin_o,
	input wire logic        irq_o
);
	logic [15:0] c0_r, cnt_r;
	logic [7:0]  presc_r;
	logic [3:0]  mask_r;
	logic        sck_q_r, ran_r;
	// Shadow copies of the link settings, taken on the same edge as the core takes the write
	wire         take_w    = avs_write_i && avs_waitrequest_o;
	wire [15:0]  c0_nxt    = (take_w && avs_address_i == SSP_OFF_CTRL0) ? avs_writedata_i[15:0] : c0_r;
	wire [3:0]   mask_nxt  = (take_w && avs_address_i == SSP_OFF_IMASK) ? avs_writedata_i[3:0] : mask_r;
	wire [7:0]   presc_w   = (avs_writedata_i[7:1] == 7'h00) ? SSP_PRESC_MIN : {avs_writedata_i[7:1], 1'b0};
	wire [7:0]   presc_nxt = (take_w && avs_address_i == SSP_OFF_PRESC) ? presc_w : presc_r;
	wire         spi_w     = c0_r[5:4] == 2'h0;
	wire [15:0]  half_w    = 16'(presc_r[7:1]) * (16'(c0_r[15:8]) + 16'h0001);

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	// Cycles since the clock pin last moved, and whether it already moved in this frame
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			c0_r    <= SSP_CTRL0_RST;
			presc_r <= SSP_PRESC_RST;
			mask_r  <= SSP_IMASK_RST;
			sck_q_r <= 1'b0;
			cnt_r   <= 16'h0000;
			ran_r   <= 1'b0;
		end else begin
			c0_r    <= c0_nxt;
			presc_r <= presc_nxt;
			mask_r  <= mask_nxt;
			sck_q_r <= serial_clock_pin_o;
			cnt_r   <= (serial_clock_pin_o != sck_q_r) ? 16'h0001 : cnt_r + 16'h0001;
			ran_r   <= !frame_select_pin_o && (ran_r || serial_clock_pin_o != sck_q_r);
		end
	end

	// Bus handshake: one wait cycle, one answer cycle, never unasked
	a_wait_one: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
		else $error("request not answered after one wait cycle");
	a_wait_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("waitrequest low for more than one cycle");
	a_wait_cause: assert property ($fell(avs_waitrequest_o) |-> $past(avs_read_i) || $past(avs_write_i))
		else $error("answer without a request");
	a_unmapped_zero: assert property (!avs_waitrequest_o && $past(avs_read_i) && $past(avs_address_i) > 6'h20
		|-> avs_readdata_o == 32'h0000_0000)
		else $error("unmapped read not zero");
	// Interrupt only through an enabled mask bit
	a_irq_masked: assert property (irq_o |-> $past(mask_r) != 4'h0)
		else $error("interrupt with all sources masked");
	// Select format: clock rests at the polarity level outside frames; outside pulsed format it moves only inside them
	a_clk_idle: assert property (spi_w && serial_clock_pin_oe_o && $past(serial_clock_pin_oe_o)
		&& frame_select_pin_o && $past(frame_select_pin_o) |-> serial_clock_pin_o == c0_r[6])
		else $error("idle clock level wrong");
	a_clk_frame: assert property (serial_clock_pin_oe_o && $past(serial_clock_pin_oe_o)
		&& c0_r[5:4] != 2'h1 && $changed(serial_clock_pin_o) |-> !frame_select_pin_o)
		else $error("clock moved outside a frame");
	// Half period equals half the prescale divisor times one plus the rate factor
	a_half_period: assert property (spi_w && !c0_r[7] && ran_r && !frame_select_pin_o
		&& $changed(serial_clock_pin_o) |-> cnt_r == half_w)
		else $error("serial clock half period wrong");

	cover property (spi_w && $fell(frame_select_pin_o));
	cover property ($rose(irq_o));
	cover property (ran_r && $changed(serial_clock_pin_o));
endmodule : ssp_core_properties

bind ssp_core ssp_core_properties u_props (.clk_i, .reset_n_i, .avs_address_i, .avs_read_i, .avs_write_i,
	.avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .serial_clock_pin_o, .serial_clock_pin_oe_o,
	.frame_select_pin_o, .irq_o);

// ==== verification/ssp_spi_slave_model.sv ====
`timescale 1ns/1ps
// Far-end peripheral in the select format: eight-bit words, any clock mode
module ssp_spi_slave_model (
	input  wire logic       sck_i,
	input  wire logic       sel_n_i,
	input  wire logic       mosi_i,
	input  wire logic       cpol_i,
	input  wire logic       cpha_i,
	input  wire logic [7:0] resp_i,
	output logic            miso_o,
	output logic [7:0]      got_o
);
	logic [7:0] sh_r;
	// High on the capture edge in every mode, so one pair of processes serves all four
	wire        cap_w = sck_i ^ cpol_i ^ cpha_i;

	initial begin
		miso_o = 1'b0;
		got_o  = 8'h00;
		sh_r   = 8'h00;
	end
	always @(posedge cap_w) begin
		if (!sel_n_i) begin
			got_o <= {got_o[6:0], mosi_i};
		end
	end
	// MSB first at select fall when phase is clear
	always @(negedge sel_n_i) begin
		sh_r = resp_i;
		if (!cpha_i) begin
			miso_o = sh_r[7];
			sh_r   = {sh_r[6:0], 1'b0};
		end
	end
	always @(negedge cap_w) begin
		if (!sel_n_i) begin
			miso_o = sh_r[7];
			sh_r   = {sh_r[6:0], 1'b0};
		end
	end
	// A released line flips so a stale bit never passes for data
	always @(posedge sel_n_i) begin
		miso_o = ~miso_o;
	end
endmodule : ssp_spi_slave_model

// ==== verification/ssp_core_tb.sv ====
`timescale 1ns/1ps
module ssp_core_tb;
	import ssp_pkg::*;
	logic        clk_i, reset_n_i, avs_read_i, avs_write_i, cpol, cpha;
	logic [5:0]  avs_address_i;
	logic [31:0] avs_writedata_i, avs_readdata_o;
	logic        avs_waitrequest_o, serial_clock_pin_o, serial_clock_pin_oe_o, frame_select_pin_o;
	logic        frame_select_pin_oe_o, serial_out_pin_o, serial_out_pin_oe_o, serial_in_pin_i, irq_o, dma_tx_req_o;
	logic [7:0]  resp, got;
	int          n_errors, checks;
	// Undriven select floats high on its pull-up, undriven clock rests at the idle level
	wire         sel_w = frame_select_pin_oe_o ? frame_select_pin_o : 1'b1;
	wire         sck_w = serial_clock_pin_oe_o ? serial_clock_pin_o : cpol;

	ssp_core DUT (.clk_i, .reset_n_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_readdata_o,
		.avs_waitrequest_o, .serial_clock_pin_i(1'b0), .serial_clock_pin_o, .serial_clock_pin_oe_o,
		.frame_select_pin_i(1'b1), .frame_select_pin_o, .frame_select_pin_oe_o, .serial_out_pin_o,
		.serial_out_pin_oe_o, .serial_in_pin_i, .irq_o, .dma_tx_req_o);
	ssp_spi_slave_model PEER (.sck_i(sck_w), .sel_n_i(sel_w), .mosi_i(serial_out_pin_o), .cpol_i(cpol),
		.cpha_i(cpha), .resp_i(resp), .miso_o(serial_in_pin_i), .got_o(got));

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			n_errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	task automatic test_done;
		$display("checks=%0d errors=%0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : test_done
	// One access: held until waitrequest is seen low, released, then one idle edge
	task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		avs_address_i   <= a;
		avs_writedata_i <= d;
		avs_write_i     <= wr;
		avs_read_i      <= !wr;
		@(posedge clk_i);
		while (avs_waitrequest_o !== 1'b0 && n < 50) begin
			@(posedge clk_i);
			n++;
		end
		q = avs_readdata_o;
		if (n == 50) n_errors++;
		avs_write_i <= 1'b0;
		avs_read_i  <= 1'b0;
		@(posedge clk_i);
	endtask : bus
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr
	task automatic rd_chk(input logic [5:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0000_0000, q);
		chk(q, e);
	endtask : rd_chk
	// Poll status until the engine is idle with a received word waiting
	task automatic wait_done;
		logic [31:0] q;
		int n;
		n = 0;
		do begin
			bus(1'b0, SSP_OFF_STATUS, 32'h0000_0000, q);
			n++;
		end while ((q[4] !== 1'b0 || q[2] !== 1'b1) && n < 100);
		if (n == 100) n_errors++;
	endtask : wait_done

	task automatic t_regs;
		rd_chk(SSP_OFF_CTRL0, 32'h0000_0007);
		rd_chk(SSP_OFF_PRESC, 32'h0000_0002);
		wr(SSP_OFF_PRESC, 32'h0000_0005);
		rd_chk(SSP_OFF_PRESC, 32'h0000_0004);
		wr(SSP_OFF_PRESC, 32'h0000_0000);
		rd_chk(SSP_OFF_PRESC, 32'h0000_0002);
		rd_chk(6'h3C, 32'h0000_0000);
		wr(SSP_OFF_PRESC, 32'h0000_0004);
		$display("registers done");
	endtask : t_regs
	// Transmit service is raw while the buffer is empty; the mask gates it
	task automatic t_irq;
		rd_chk(SSP_OFF_RIS, 32'h0000_0008);
		chk({31'h0, irq_o}, 32'h0);
		wr(SSP_OFF_IMASK, 32'h0000_0008);
		rd_chk(SSP_OFF_MIS, 32'h0000_0008);
		chk({31'h0, irq_o}, 32'h1);
		wr(SSP_OFF_IMASK, 32'h0000_0000);
		chk({31'h0, irq_o}, 32'h0);
		wr(SSP_OFF_CTRL1, 32'h0000_000A);
		repeat (2) @(posedge clk_i);
		chk({31'h0, dma_tx_req_o}, 32'h1);
		wr(SSP_OFF_CTRL1, 32'h0000_0000);
		$display("interrupts done");
	endtask : t_irq
	// One eight-bit word each way in the given clock mode
	task automatic t_spi(input logic pol, input logic pha, input logic [7:0] w);
		cpol <= pol;
		cpha <= pha;
		resp <= ~w;
		wr(SSP_OFF_CTRL1, 32'h0000_0000);
		wr(SSP_OFF_CTRL0, {16'h0000, 8'h01, pha, pol, 2'b00, 4'h7});
		wr(SSP_OFF_CTRL1, 32'h0000_0002);
		wr(SSP_OFF_DATA, {24'h0, w});
		wait_done;
		chk({24'h0, got}, {24'h0, w});
		rd_chk(SSP_OFF_DATA, {24'h0, ~w});
		$display("select format mode %0d%0d done", pol, pha);
	endtask : t_spi
	// Unread word: no time-out well inside 32 bit periods, time-out after them
	task automatic t_timeout;
		logic [31:0] q;
		wr(SSP_OFF_DATA, 32'h0000_005A);
		wait_done;
		repeat (150) @(posedge clk_i);
		bus(1'b0, SSP_OFF_RIS, 32'h0000_0000, q);
		chk({31'h0, q[SSP_IRQ_RTO]}, 32'h0);
		repeat (150) @(posedge clk_i);
		bus(1'b0, SSP_OFF_RIS, 32'h0000_0000, q);
		chk({31'h0, q[SSP_IRQ_RTO]}, 32'h1);
		wr(SSP_OFF_ICR, 32'h0000_0002);
		rd_chk(SSP_OFF_DATA, {24'h0, resp});
		$display("time-out done");
	endtask : t_timeout

	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	// Watchdog sized well above the several hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge clk_i);
		n_errors++;
		test_done;
	end
	initial begin
		{reset_n_i, avs_read_i, avs_write_i, cpol, cpha} = 5'b00000;
		avs_address_i   = 6'h00;
		avs_writedata_i = 32'h0000_0000;
		resp            = 8'h00;
		n_errors        = 0;
		checks          = 0;
		repeat (20) @(posedge clk_i);
		reset_n_i <= 1'b1;
		@(posedge clk_i);
		t_regs;
		t_irq;
		for (int m = 0; m < 4; m++) begin
			t_spi(m[1], m[0], 8'hA5 ^ 8'(m * 17));
		end
		t_timeout;
		test_done;
	end
endmodule : ssp_core_tb
